// >>> result_bank_pkg.sv
package result_bank_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_AMBIENT_CH2 = 8'h2B;
  localparam logic [7:0] ADDR_AMBIENT_CH1 = 8'h2D;
  localparam logic [7:0] ADDR_CH2_MINUS = 8'h2E;
  localparam logic [7:0] ADDR_CH1_MINUS = 8'h2F;
  localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h30;

  // Widths
  localparam int DATA_W = 24;
  localparam int FLAG_W = 13;

  // Reset values
  localparam logic [23:0] SAMPLE_RST = 24'h000000;
  localparam logic [23:0] DIFF_RST = 24'h000000;
  localparam logic [12:0] FLAGS_RST = 13'h0000;
  localparam logic [23:0] READ_ZERO = 24'h000000;
  localparam logic [10:0] FLAG_PAD = 11'h000;

  // Fault flag layout, bit 12 down to bit 0
  typedef struct packed {
    logic photodiode_alarm;
    logic emitter_alarm;
    logic emitter_one_open;
    logic emitter_two_open;
    logic emitter_shorted;
    logic pos_output_to_ground;
    logic neg_output_to_ground;
    logic photodiode_open;
    logic photodiode_shorted;
    logic neg_input_to_ground;
    logic pos_input_to_ground;
    logic neg_input_to_emitter;
    logic pos_input_to_emitter;
  } fault_flags_s;

  // Converter result strobe with data
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } sample_s;

  // Register read port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [23:0] wdata;
  } reg_req_s;

endpackage : result_bank_pkg

// >>> result_bank.sv
`timescale 1ns/1ns
`default_nettype none

// One ambient path, used once per emitter channel
// Keeps the newest raw sample and the newest ambient sample
// Forms raw minus ambient when the ambient sample lands
// Raw must come before its ambient; the latest stored raw is used
// One copy per channel keeps the two channels identical
// The difference wraps at the sample width and keeps the
// native sign of the subtraction
module ambient_path #(
  parameter int W = result_bank_pkg::DATA_W // Sample width
) (
  input wire logic mclk, // Device clock
  input wire logic arst_n, // Async reset, active low
  input wire result_bank_pkg::sample_s raw_in, // Raw emitter sample
  input wire result_bank_pkg::sample_s amb_in, // Ambient sample
  output logic [W-1:0] amb_value, // Newest ambient value
  output logic [W-1:0] diff_value // Raw minus ambient
);
  import result_bank_pkg::*;

  // Everything this path remembers
  typedef struct packed {
    logic [W-1:0] raw; // Newest raw sample
    logic [W-1:0] amb; // Newest ambient sample
    logic [W-1:0] diff; // Ambient-corrected result
  } path_s;

  path_s path_ff; // Registered path state
  path_s nxt_path; // Next path state

  // Next-state logic for one channel
  // Both strobes may land together; the difference then
  // still uses the raw value held before that edge
  always_comb begin
    nxt_path = path_ff;
    // Raw sample kept only as the minuend
    if (raw_in.valid) begin
      nxt_path.raw = raw_in.data[W-1:0];
    end
    // Ambient arrival stores value and difference together
    if (amb_in.valid) begin
      nxt_path.amb = amb_in.data[W-1:0];
      // Plain modular subtraction; no sign flip applied
      nxt_path.diff = path_ff.raw - amb_in.data[W-1:0];
    end
    // Nothing else changes; values hold until replaced
  end

  // Path register, cleared by reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // Stored samples and difference back to zero
      path_ff.raw <= SAMPLE_RST[W-1:0];
      path_ff.amb <= SAMPLE_RST[W-1:0];
      path_ff.diff <= DIFF_RST[W-1:0];
    end else begin
      // Load the whole path at once
      path_ff <= nxt_path;
    end
  end

  // Outputs straight from the path flops
  assign amb_value = path_ff.amb;
  assign diff_value = path_ff.diff;

endmodule : ambient_path

// Result bank top: register reads, pulses and fault capture
module result_bank (
  input wire logic mclk,
  input wire logic arst_n,
  input wire result_bank_pkg::reg_req_s req,
  output logic [23:0] rdata,
  output logic rvalid,
  input wire result_bank_pkg::sample_s ch1_sample,
  input wire result_bank_pkg::sample_s ch1_ambient,
  input wire result_bank_pkg::sample_s ch2_sample,
  input wire result_bank_pkg::sample_s ch2_ambient,
  input wire logic fault_flags_done_in,
  input wire result_bank_pkg::fault_flags_s fault_flags_result,
  output logic conv_ready,
  output logic fault_check_done,
  output logic photodiode_alarm,
  output logic emitter_alarm
);
  import result_bank_pkg::*;

  // Timing at a glance, one edge from strobe to result
  //   ambient strobe at edge n: value, difference and
  //     conversion-ready visible after edge n
  //   read request at edge n: read data and answer pulse
  //     visible after edge n
  //   diagnostic end at edge n: flags, alarm pins and done
  //     pulse visible after edge n
  // Limitation: nothing queues results; the host must read a
  // result before the next conversion overwrites it
  // Trade-off: the difference is formed on the ambient strobe,
  // so a raw sample must arrive before its ambient partner

  // Register map, all read-only
  //   2B  ambient sample, channel two
  //   2D  ambient sample, channel one
  //   2E  channel two minus its ambient
  //   2F  channel one minus its ambient
  //   30  fault flags in bits 12..0, upper bits zero
  // Any other address reads as zero; writes are dropped

  // Bank-level state; sample storage lives in the two paths
  typedef struct packed {
    fault_flags_s fault_flags; // Captured diagnostic word
    logic [23:0] rdata; // Read data register
    logic rvalid; // Read answer pulse
    logic conv_ready; // Conversion-ready pulse
    logic fault_check_done; // Diagnostic end pulse
  } state_s;

  state_s cur_ff; // Registered state
  state_s nxt_cur; // Next state

  // Values held by the two channel paths
  logic [23:0] amb_ch1; // Channel one ambient value
  logic [23:0] amb_ch2; // Channel two ambient value
  logic [23:0] diff_ch1; // Channel one corrected value
  logic [23:0] diff_ch2; // Channel two corrected value

  // Channel one path: ambient sample and corrected value
  // Feeds addresses 2D and 2F
  ambient_path #(
    .W(DATA_W)
  ) u_ch1_path (
    .mclk(mclk),
    .arst_n(arst_n),
    .raw_in(ch1_sample),
    .amb_in(ch1_ambient),
    .amb_value(amb_ch1),
    .diff_value(diff_ch1)
  );

  // Channel two path: same logic, second emitter
  // Feeds addresses 2B and 2E
  ambient_path #(
    .W(DATA_W)
  ) u_ch2_path (
    .mclk(mclk),
    .arst_n(arst_n),
    .raw_in(ch2_sample),
    .amb_in(ch2_ambient),
    .amb_value(amb_ch2),
    .diff_value(diff_ch2)
  );

  // Next-state logic for pulses, flags and read data
  always_comb begin
    nxt_cur = cur_ff;
    // Pulses last one cycle unless raised again below
    nxt_cur.conv_ready = 1'h0;
    nxt_cur.fault_check_done = 1'h0;
    nxt_cur.rvalid = 1'h0;

    // Conversion-ready on either ambient update
    // The path stores the value at the same edge, so a host that
    // reacts to the pulse always reads the new sample
    // Two strobes in one cycle give a single pulse
    if (ch1_ambient.valid) begin
      nxt_cur.conv_ready = 1'h1;
    end
    if (ch2_ambient.valid) begin
      nxt_cur.conv_ready = 1'h1;
    end

    // Diagnostic end: the whole flag word is loaded at one edge,
    // so a read never returns a mix of old and new flags
    // A flag reads 1 for a fault and 0 for none
    if (fault_flags_done_in) begin

      // Alarm flags, mirrored on their own pins
      // Bit 12, photodiode-side alarm
      nxt_cur.fault_flags.photodiode_alarm =
        fault_flags_result.photodiode_alarm;
      // Bit 11, emitter-side alarm
      nxt_cur.fault_flags.emitter_alarm =
        fault_flags_result.emitter_alarm;

      // Emitter open and short flags
      // Bit 10, first emitter open
      nxt_cur.fault_flags.emitter_one_open =
        fault_flags_result.emitter_one_open;
      // Bit 9, second emitter open
      nxt_cur.fault_flags.emitter_two_open =
        fault_flags_result.emitter_two_open;
      // Bit 8, emitter shorted
      nxt_cur.fault_flags.emitter_shorted =
        fault_flags_result.emitter_shorted;

      // Transmit output shorts to the ground cable
      // Bit 7, positive output
      nxt_cur.fault_flags.pos_output_to_ground =
        fault_flags_result.pos_output_to_ground;
      // Bit 6, negative output
      nxt_cur.fault_flags.neg_output_to_ground =
        fault_flags_result.neg_output_to_ground;

      // Photodiode flags
      // Bit 5, photodiode open
      nxt_cur.fault_flags.photodiode_open =
        fault_flags_result.photodiode_open;
      // Bit 4, photodiode shorted
      nxt_cur.fault_flags.photodiode_shorted =
        fault_flags_result.photodiode_shorted;

      // Receive input shorts
      // Bit 3, negative input to ground cable
      nxt_cur.fault_flags.neg_input_to_ground =
        fault_flags_result.neg_input_to_ground;
      // Bit 2, positive input to ground cable
      nxt_cur.fault_flags.pos_input_to_ground =
        fault_flags_result.pos_input_to_ground;
      // Bit 1, negative input to emitter cable
      nxt_cur.fault_flags.neg_input_to_emitter =
        fault_flags_result.neg_input_to_emitter;
      // Bit 0, positive input to emitter cable
      nxt_cur.fault_flags.pos_input_to_emitter =
        fault_flags_result.pos_input_to_emitter;

      // End-of-sequence pulse on its own pin
      nxt_cur.fault_check_done = 1'h1;
    end

    // Read decode; a write never reaches this path
    // Reads answer from flops only, so a read in the same cycle
    // as an update returns the old value
    if (req.rd) begin
      // Every read is answered one cycle later
      nxt_cur.rvalid = 1'h1;
      if (req.addr == ADDR_AMBIENT_CH1) begin
        // Ambient sample, channel one
        nxt_cur.rdata = amb_ch1;
      end else if (req.addr == ADDR_AMBIENT_CH2) begin
        // Ambient sample, channel two
        nxt_cur.rdata = amb_ch2;
      end else if (req.addr == ADDR_CH2_MINUS) begin
        // Channel two minus its ambient
        nxt_cur.rdata = diff_ch2;
      end else if (req.addr == ADDR_CH1_MINUS) begin
        // Channel one minus its ambient
        nxt_cur.rdata = diff_ch1;
      end else if (req.addr == ADDR_FAULT_FLAGS) begin
        // Fault word with zero padding on top
        nxt_cur.rdata = {FLAG_PAD, cur_ff.fault_flags};
      end else begin
        // Unmapped address reads as zero
        nxt_cur.rdata = READ_ZERO;
      end
    end
  end

  // State register; reset clears every flag and pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // Captured flags back to no fault
      cur_ff.fault_flags <= FLAGS_RST;
      // Read data register empty
      cur_ff.rdata <= READ_ZERO;
      // All pulses low
      cur_ff.rvalid <= 1'h0;
      cur_ff.conv_ready <= 1'h0;
      cur_ff.fault_check_done <= 1'h0;
    end else begin
      // Load the whole state at once
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from flops
  // No logic between the flops and the pins
  assign rdata = cur_ff.rdata;
  assign rvalid = cur_ff.rvalid;
  assign conv_ready = cur_ff.conv_ready;
  assign fault_check_done = cur_ff.fault_check_done;
  // Alarm pins follow the captured flag bits
  assign photodiode_alarm = cur_ff.fault_flags.photodiode_alarm;
  assign emitter_alarm = cur_ff.fault_flags.emitter_alarm;

endmodule : result_bank
`default_nettype wire

// >>> result_bank_sva.sv
`timescale 1ns/1ns
`default_nettype none
module result_bank_sva (
  input wire logic mclk,
  input wire logic arst_n,
  input wire result_bank_pkg::reg_req_s req,
  input wire logic [23:0] rdata,
  input wire logic rvalid,
  input wire result_bank_pkg::sample_s ch1_ambient,
  input wire result_bank_pkg::sample_s ch2_ambient,
  input wire logic fault_flags_done_in,
  input wire result_bank_pkg::fault_flags_s fault_flags_result,
  input wire logic conv_ready,
  input wire logic fault_check_done,
  input wire logic photodiode_alarm,
  input wire logic emitter_alarm
);
  import result_bank_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  // Any ambient arrival
  wire logic amb = ch1_ambient.valid | ch2_ambient.valid;
  a_ready_pulse: assert property (amb |=> conv_ready)
    else $error("ready missing");
  a_ready_cause: assert property (conv_ready |-> $past(amb))
    else $error("stray ready");
  a_done_pulse:
    assert property (fault_flags_done_in |=> fault_check_done ##1 !fault_check_done)
    else $error("done pulse wrong");
  a_alarm_pins:
    assert property (fault_flags_done_in |=>
      {photodiode_alarm, emitter_alarm} == $past(fault_flags_result[12:11]))
    else $error("alarm pins wrong");
  a_pins_hold:
    assert property (!fault_flags_done_in |=>
      $stable({photodiode_alarm, emitter_alarm}))
    else $error("alarm pins moved");
  a_read_answer: assert property (req.rd |=> rvalid)
    else $error("read unanswered");
  a_write_quiet: assert property (!req.rd |=> !rvalid)
    else $error("answer without read");
  a_flag_pad:
    assert property (req.rd && req.addr == ADDR_FAULT_FLAGS |=>
      rdata[23:13] == FLAG_PAD)
    else $error("flag pad not zero");
  // Main scenarios seen
  cover property (amb ##1 conv_ready);
  cover property (fault_flags_done_in ##1 photodiode_alarm);
  cover property (req.wr);
endmodule : result_bank_sva
`default_nettype wire

// >>> host_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic mclk,
  output result_bank_pkg::reg_req_s req,
  input wire logic [23:0] rdata
);
  import result_bank_pkg::*;
  // One access; read data is taken at the next falling edge
  task automatic acc(input logic [7:0] a, input logic w, output logic [23:0] d);
    @(negedge mclk) req = '{~w, w, a, 24'hFFFFFF};
    @(negedge mclk) req = '{1'b0, 1'b0, ~a, 24'h000000};
    d = rdata;
  endtask : acc
  initial req = '0;
endmodule : host_model
`default_nettype wire

// >>> test_result_bank.sv
`timescale 1ns/1ns
`default_nettype none
module test_result_bank;
  import result_bank_pkg::*;
  logic mclk = 1'h0, arst_n = 1'h0, fault_flags_done_in = 1'h0;
  sample_s s1 = '0, a1 = '0, s2 = '0, a2 = '0;
  fault_flags_s dres = '0;
  reg_req_s req;
  logic [23:0] rdata, d;
  logic rvalid, conv_ready, fault_check_done, photodiode_alarm, emitter_alarm;
  logic [12:0] pat [2] = '{13'h1A55, 13'h05AA};
  int num_errors = 0, checked = 0;
  result_bank dut(.mclk, .arst_n, .req, .rdata, .rvalid, .ch1_sample(s1),
    .ch1_ambient(a1), .ch2_sample(s2), .ch2_ambient(a2), .fault_flags_done_in,
    .fault_flags_result(dres), .conv_ready, .fault_check_done, .photodiode_alarm,
    .emitter_alarm);
  host_model host(.mclk, .req, .rdata);
  initial forever #20 mclk = ~mclk;
  task automatic chk(input logic [23:0] got, exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [23:0] e);
    host.acc(a, 1'h0, d);
    chk(d, e);
    chk({23'h000000, rvalid}, 24'h000001);
  endtask : rchk
  task automatic print_verdict;
    if (num_errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : print_verdict
  // Watchdog
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge mclk);
    arst_n = 1'h1;
    rchk(8'h2E, 24'h000000);
    rchk(8'h2F, 24'h000000);
    rchk(8'h30, 24'h000000);
    @(negedge mclk) {s1, s2} = {1'h1, 24'h000010, 1'h1, 24'h800005};
    @(negedge mclk) {s1, s2, a1, a2} = {50'h0, 1'h1, 24'h000030,
      1'h1, 24'h000002};
    @(negedge mclk) {a1, a2} = 50'h0;
    chk({23'h000000, conv_ready}, 24'h000001);
    rchk(8'h2D, 24'h000030);
    chk({23'h000000, conv_ready}, 24'h000000);
    rchk(8'h2F, 24'hFFFFE0);
    rchk(8'h2E, 24'h800003);
    rchk(8'h2B, 24'h000002);
    host.acc(8'h2D, 1'h1, d);
    chk({23'h000000, rvalid}, 24'h000000);
    rchk(8'h2D, 24'h000030);
    rchk(8'h31, 24'h000000);
    foreach (pat[i]) begin
      @(negedge mclk) {fault_flags_done_in, dres} = {1'h1, pat[i]};
      @(negedge mclk) {fault_flags_done_in, dres} = 14'h0000;
      chk({23'h000000, fault_check_done}, 24'h000001);
      chk({22'h0, photodiode_alarm, emitter_alarm}, pat[i] >> 11);
      rchk(8'h30, {11'h000, pat[i]});
    end
    print_verdict();
  end
endmodule : test_result_bank
bind result_bank result_bank_sva u_sva(.*);
`default_nettype wire
